// File: pkg/acm_pkg.sv
// Constants, codes and state type of the converter mode control block.
// Assumes an APB master on pclk and converter logic on the same clock.
package acm_pkg;

  // ****************************************************************
  // Clocking and counter sizes
  // ****************************************************************
  localparam int CLK_KHZ       = 100000;
  localparam int CONV_KHZ_DFLT = 2000;
  localparam int CNT_W         = 24;
  localparam int DIV_W         = 16;

  // ****************************************************************
  // Register map (index times four gives the byte address)
  // ****************************************************************
  localparam logic [7:0]  MODE_IDX   = 8'h01;
  localparam logic [7:0]  STAT_IDX   = 8'h00;
  localparam logic [7:0]  MODE_ADDR  = {MODE_IDX[5:0], 2'b00};
  localparam logic [7:0]  STAT_ADDR  = {STAT_IDX[5:0], 2'b00};
  localparam logic [15:0] MODE_RST   = 16'h2000;
  localparam logic [15:0] MODE_WMASK = 16'he77c;

  // ****************************************************************
  // Mode register fields
  // ****************************************************************
  localparam int REF_BIT  = 15;
  localparam int SETL_BIT = 13;
  localparam int DLY_LSB  = 8;
  localparam int MODE_LSB = 4;
  localparam int CSEL_LSB = 2;

  // Operating modes
  localparam logic [2:0] M_CONT = 3'h0;
  localparam logic [2:0] M_SING = 3'h1;
  localparam logic [2:0] M_STBY = 3'h2;
  localparam logic [2:0] M_PDWN = 3'h3;

  // Clock sources
  localparam logic [1:0] CS_INT     = 2'h0;
  localparam logic [1:0] CS_INT_OUT = 2'h1;
  localparam logic [1:0] CS_EXT     = 2'h2;
  localparam logic [1:0] CS_XTAL    = 2'h3;

  // Settling delays in microseconds, by code
  localparam int DLY_US [8] = '{0, 32, 128, 320, 800, 1600, 4000, 8000};

  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b001,
    ST_SETTLE = 3'b010,
    ST_RUN    = 3'b100
  } acm_state_t;

endpackage

// File: hdl/acm_mode_control.sv
// Converter mode register, clock source control and settling sequencer.
// Assumes an APB master on pclk; the filter and channel sequencer run
// on pclk too, while the clock pin comes from outside and is synchronised.
//
// The APB slave port was decided locally.
`timescale 1ns/1ns

module acm_mode_control
  import acm_pkg::*;
#(
  parameter int CONV_CLK_KHZ = CONV_KHZ_DFLT
)
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Converter side
  input  wire logic        channel_switch,
  input  wire logic        single_channel,
  input  wire logic        result_valid,
  input  wire logic        result_settled,
  output logic             filter_reset,
  output logic             process_start,
  output logic             data_ready,
  output logic      [2:0]  op_mode,
  output logic             settled_only_output,
  output logic             conv_tick,
  // Reference and clock pins
  output logic             ref_out_enable,
  output logic             osc_enable,
  output logic             crystal_enable,
  input  wire logic        clock_io_in,
  output logic             clock_io_out,
  output logic             clock_io_oe
);

  localparam int OSC_HALF = CLK_KHZ / (2 * CONV_CLK_KHZ);

  // Refuse clock rates the divider cannot make
  if (CONV_CLK_KHZ < 1 || OSC_HALF < 1 || OSC_HALF >= (1 << DIV_W))
  begin : g_bad_rate
    $error("CONV_CLK_KHZ out of range");
  end

  // ****************************************************************
  // Delay code to conversion clock ticks, rounded up
  // ****************************************************************
  function automatic logic [CNT_W-1:0] delay_ticks(input logic [2:0] code);
    longint t;
    t = (longint'(DLY_US[code]) * CONV_CLK_KHZ + 999) / 1000;
    return t[CNT_W-1:0];
  endfunction

  // ****************************************************************
  // Register interface
  // ****************************************************************
  logic [15:0] mode_reg;
  logic [15:0] mode_next;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic        wr_mode;
  logic        hit;
  logic [15:0] wdata_m;
  logic [15:0] status_w;

  acm_state_t      state_reg;
  acm_state_t      state_next;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic            start_reg;
  logic            start_next;
  logic            filt_reg;
  logic            filt_next;
  logic            ready_reg;
  logic            ready_next;

  // Decode, byte lanes and read data capture
  always_comb
  begin
    hit     = (paddr == MODE_ADDR) || (paddr == STAT_ADDR);
    wr_mode = psel && penable && pwrite && (paddr == MODE_ADDR);
    pready  = 1'b1;
    pslverr = psel && penable && !hit;
    wdata_m = mode_reg;
    for (int i = 0; i < 2; i++)
      if (pstrb[i])
        wdata_m[i*8 +: 8] = pwdata[i*8 +: 8];  // Lanes 2 and 3 unused
    mode_next = mode_reg;
    if (wr_mode)
      mode_next = wdata_m & MODE_WMASK;  // Reserved read-only bits stay 0
    status_w = {11'h000, (state_reg == ST_SETTLE), state_reg, ready_reg};
    prdata_next = prdata_reg;
    if (psel && !penable && !pwrite)
    begin
      prdata_next = 32'h0000_0000;  // Unmapped reads return zero
      if (paddr == MODE_ADDR)
        prdata_next = {16'h0000, mode_reg};
      else if (paddr == STAT_ADDR)
        prdata_next = {16'h0000, status_w};
    end
  end

  // Register storage, reset to documented default
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_reg   <= MODE_RST;
      prdata_reg <= 32'h0000_0000;
    end
    else
    begin
      mode_reg   <= mode_next;
      prdata_reg <= prdata_next;
    end
  end

  assign prdata = prdata_reg;

  // ****************************************************************
  // Field decode
  // ****************************************************************
  logic [1:0] clk_sel;
  logic [2:0] dly_code;

  // Fields steer mode, clock and reference pins
  assign op_mode             = mode_reg[MODE_LSB +: 3];
  assign clk_sel             = mode_reg[CSEL_LSB +: 2];
  assign dly_code            = mode_reg[DLY_LSB +: 3];
  assign settled_only_output = mode_reg[SETL_BIT];
  assign ref_out_enable      = mode_reg[REF_BIT];
  assign osc_enable          = !clk_sel[1];
  assign crystal_enable      = (clk_sel == CS_XTAL);
  assign clock_io_oe         = (clk_sel == CS_INT_OUT);

  // ****************************************************************
  // Conversion clock: internal divider or synchronised pin
  // ****************************************************************
  logic [DIV_W-1:0] div_reg;
  logic [DIV_W-1:0] div_next;
  logic             osc_reg;
  logic             osc_next;
  logic             int_tick;
  logic [2:0]       sync_reg;
  logic [2:0]       sync_next;
  logic             lvl_reg;
  logic             lvl_next;
  logic             ext_tick;

  // Oscillator divider and pin level filter
  always_comb
  begin
    div_next = div_reg;
    osc_next = osc_reg;
    int_tick = 1'b0;
    if (!osc_enable)
    begin
      div_next = '0;
      osc_next = 1'b0;
    end
    else if (div_reg == DIV_W'(OSC_HALF - 1))
    begin
      div_next = '0;
      osc_next = !osc_reg;
      int_tick = osc_reg;  // One tick per full period
    end
    else
      div_next = div_reg + 1'b1;
    sync_next = {sync_reg[1:0], clock_io_in};
    lvl_next  = lvl_reg;
    if (sync_reg[1] == sync_reg[2])
      lvl_next = sync_reg[2];
    ext_tick  = lvl_next && !lvl_reg;
    conv_tick = clk_sel[1] ? ext_tick : int_tick;
  end

  // Clock state registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div_reg  <= '0;
      osc_reg  <= 1'b0;
      sync_reg <= 3'b000;
      lvl_reg  <= 1'b0;
    end
    else
    begin
      div_reg  <= div_next;
      osc_reg  <= osc_next;
      sync_reg <= sync_next;
      lvl_reg  <= lvl_next;
    end
  end

  assign clock_io_out = osc_reg;  // Toggles for both internal sources, not only while oe is high

  // ****************************************************************
  // Conversion sequencer
  // ****************************************************************
  logic       accept;
  logic [2:0] new_mode;

  // Restart, settle, run and result acceptance
  always_comb
  begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    start_next = 1'b0;
    filt_next  = 1'b0;
    ready_next = ready_reg;
    new_mode   = mode_next[MODE_LSB +: 3];
    accept     = result_valid && (state_reg == ST_RUN) &&
                 (!(settled_only_output && single_channel) ||
                  result_settled);
    if (wr_mode)
    begin
      filt_next  = 1'b1;
      ready_next = 1'b0;
      cnt_next   = delay_ticks(mode_next[DLY_LSB +: 3]);
      if (new_mode == M_STBY || new_mode == M_PDWN)
        state_next = ST_IDLE;
      else
        state_next = ST_SETTLE;
    end
    else
    begin
      case (state_reg)
        ST_SETTLE:
        begin
          if (cnt_reg == '0)
          begin
            state_next = ST_RUN;
            start_next = 1'b1;
          end
          else if (conv_tick)
            cnt_next = cnt_reg - 1'b1;
        end
        ST_RUN:
        begin
          if (accept)
            ready_next = 1'b1;
          if (channel_switch)
          begin
            cnt_next   = delay_ticks(dly_code);
            state_next = ST_SETTLE;
          end
          else if (accept && op_mode != M_CONT)
            state_next = ST_IDLE;  // Single and calibrations end
        end
        default:
          state_next = state_reg;
      endcase
    end
  end

  // Sequencer registers; reset starts continuous conversion
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg <= ST_SETTLE;
      cnt_reg   <= '0;
      start_reg <= 1'b0;
      filt_reg  <= 1'b0;
      ready_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      start_reg <= start_next;
      filt_reg  <= filt_next;
      ready_reg <= ready_next;
    end
  end

  assign filter_reset  = filt_reg;
  assign process_start = start_reg;
  assign data_ready    = ready_reg;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_mode_write;
    wr_mode;
  endsequence

  sequence s_restart;
    filt_reg && !ready_reg;
  endsequence

  a_write_restart: assert property (
    s_mode_write |=> s_restart ##1 !filt_reg)
    else $error("mode write did not restart filter");
  a_reset_value: assert property (
    $rose(presetn) |-> mode_reg == MODE_RST)
    else $error("mode register reset value wrong");
  a_ref_enable: assert property (
    wr_mode && pstrb[1] |=> ref_out_enable == $past(pwdata[REF_BIT]))
    else $error("reference enable not following write");
  a_settled_gate: assert property (
    $rose(data_ready) && $past(settled_only_output && single_channel)
    |-> $past(result_settled))
    else $error("unsettled result delivered");
  a_settle_wait: assert property (
    process_start |-> $past(state_reg == ST_SETTLE && cnt_reg == '0))
    else $error("processing began before settling");
  a_delay_load: assert property (
    state_reg == ST_RUN && channel_switch && !wr_mode
    |=> state_reg == ST_SETTLE && cnt_reg == delay_ticks(dly_code))
    else $error("settling delay loaded wrong");
  a_standby_idle: assert property (
    wr_mode && pstrb[0] && pwdata[MODE_LSB +: 3] == M_STBY
    |=> state_reg == ST_IDLE ##1 !process_start)
    else $error("standby did not stop sequencer");
  a_clock_pin: assert property (
    clock_io_oe |-> !clk_sel[1] && !crystal_enable && osc_enable)
    else $error("clock pin driven with wrong source");
  a_osc_power: assert property (
    conv_tick && !clk_sel[1] |-> osc_enable && $past(osc_reg))
    else $error("internal tick without oscillator");
  a_count_restart: assert property (
    s_mode_write ##1 state_reg == ST_SETTLE
    |-> cnt_reg == delay_ticks(dly_code))
    else $error("settling counter not restarted");

endmodule

// File: verification/tb.sv
// Self-checking bench for the converter mode control block.
// Assumes a zero-wait APB slave and settling counted in conv ticks.
`timescale 1ns/1ns

module tb;
  import acm_pkg::*;

  // ****************************************************************
  // Signals
  // ****************************************************************
  localparam int SIM_KHZ = 25000;
  localparam int LIMIT   = 60000;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb;
  logic        channel_switch, single_channel, result_valid;
  logic        result_settled, filter_reset, process_start, data_ready;
  logic [2:0]  op_mode;
  logic        settled_only_output, conv_tick, ref_out_enable;
  logic        osc_enable, crystal_enable, clock_io_in, clock_io_out;
  logic        clock_io_oe, err;
  logic [15:0] v;
  int          miscompares, check_count, cycles, tick_total;
  int          starts, st_tick, mark, s_mark;

  acm_mode_control #(.CONV_CLK_KHZ(SIM_KHZ)) u_acm_mode_control (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .channel_switch, .single_channel,
    .result_valid, .result_settled, .filter_reset, .process_start,
    .data_ready, .op_mode, .settled_only_output, .conv_tick,
    .ref_out_enable, .osc_enable, .crystal_enable, .clock_io_in,
    .clock_io_out, .clock_io_oe);

  // ****************************************************************
  // Clocks, tick and start monitor, hang limit
  // ****************************************************************
  // Main clock
  always #5 pclk = ~pclk;

  // External clock pin, conv ticks, starts and timeout
  always @(posedge pclk)
  begin
    cycles <= cycles + 1;
    if (cycles[0]) clock_io_in <= ~clock_io_in;
    if (conv_tick === 1'b1) tick_total <= tick_total + 1;
    if (process_start === 1'b1)
    begin
      starts  <= starts + 1;
      st_tick <= tick_total;
    end
    if (cycles == LIMIT)
    begin
      miscompares++;
      give_verdict();
    end
  end

  // ****************************************************************
  // Expectations and bus tasks
  // ****************************************************************
  // Reserved positions always read back as zero
  function automatic logic [31:0] exp_rd(input logic [15:0] x);
    exp_rd = {16'h0000, x & 16'he77c};
  endfunction

  // Settling time in microseconds per delay code
  function automatic int us_of(input int c);
    int t[8];
    t = '{0, 32, 128, 320, 800, 1600, 4000, 8000};
    us_of = t[c];
  endfunction

  // Compare and count
  task automatic chk(input string nm, input logic [31:0] s, e);
    check_count++;
    if (s !== e)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask

  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [3:0] s);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Mode write, then readback and decoded outputs
  task automatic wr_mode(input logic [15:0] x);
    logic b;
    apb(1'b1, 8'h04, {16'h0000, x}, 4'hf);
    mark = tick_total;
    s_mark = starts;
    #1;
    chk("filter_reset", filter_reset, 1'b1);
    chk("ready_clear", data_ready, 1'b0);
    apb(1'b0, 8'h04, 32'h0, 4'h0);
    chk("mode_read", rd, exp_rd(x));
    chk("op_mode", op_mode, x[6:4]);
    chk("ref_out", ref_out_enable, x[15]);
    chk("settled_only", settled_only_output, x[13]);
    chk("osc_enable", osc_enable, x[3] == 1'b0);
    chk("crystal", crystal_enable, x[3:2] == 2'h3);
    chk("clock_oe", clock_io_oe, x[3:2] == 2'h1);
    // Internal oscillator flips once every two pclk edges in this bench
    if (!x[3])
    begin
      @(posedge pclk);
      #1;
      b = clock_io_out;
      repeat (2) @(posedge pclk);
      #1;
      chk("clock_out", clock_io_out, !b);
    end
  endtask

  // Wait for the next start and compare the ticks spent settling
  task automatic wait_start(input int c);
    int k;
    int n;
    int e;
    k = 0;
    while (starts == s_mark && k < LIMIT)
    begin
      @(posedge pclk);
      k++;
    end
    n = st_tick - mark;
    e = (us_of(c) * SIM_KHZ + 999) / 1000;
    chk("settle_ticks", n >= e && n <= e + 2, 1'b1);
  endtask

  // One result from the filter, then the ready level
  task automatic result(input logic st, input logic exp_dr);
    @(posedge pclk);
    result_valid   <= 1'b1;
    result_settled <= st;
    @(posedge pclk);
    result_valid <= 1'b0;
    @(posedge pclk);
    #1;
    chk("data_ready", data_ready, exp_dr);
  endtask

  // Closing report
  task give_verdict;
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    {pclk, presetn, psel, penable, pwrite, channel_switch} = '0;
    {single_channel, result_valid, result_settled, clock_io_in} = '0;
    paddr = '0;
    pwdata = '0;
    pstrb = '0;
    void'($urandom(41428));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    chk("rst_ref", ref_out_enable, 1'b0);
    chk("rst_settled", settled_only_output, 1'b1);
    chk("rst_osc", osc_enable, 1'b1);
    chk("pready", pready, 1'b1);
    apb(1'b0, 8'h04, 32'h0, 4'h0);
    chk("rst_mode", rd, 32'h0000_2000);
    // Settling after restart and after a channel switch
    for (int i = 0; i < 3; i++)
    begin
      wr_mode(16'h2000 | 16'(i << 8));
      wait_start(i);
      @(posedge pclk);
      channel_switch <= 1'b1;
      mark = tick_total;
      s_mark = starts;
      @(posedge pclk);
      channel_switch <= 1'b0;
      wait_start(i);
      single_channel <= 1'b1;
      result(1'b0, 1'b0);
      result(1'b1, 1'b1);
      single_channel <= 1'b0;
    end
    // Unsettled results pass when one of the two conditions is off
    wr_mode(16'h2000);
    wait_start(0);
    result(1'b0, 1'b1);
    apb(1'b0, 8'h00, 32'h0, 4'h0);
    chk("status_run", rd, {16'h0000, 11'h000, 1'b0, ST_RUN, 1'b1});
    wr_mode(16'h0000);
    wait_start(0);
    single_channel <= 1'b1;
    result(1'b0, 1'b1);
    // Single conversion stops after its first accepted result
    wr_mode(16'h0010);
    wait_start(0);
    result(1'b1, 1'b1);
    apb(1'b0, 8'h00, 32'h0, 4'h0);
    chk("single_idle", rd, {16'h0000, 11'h000, 1'b0, ST_IDLE, 1'b1});
    // Every mode with every clock source, random other bits
    for (int i = 0; i < 32; i++)
    begin
      v = 16'($urandom);
      v[6:4] = i[2:0];
      v[3:2] = i[4:3];
      v = v & 16'ha77c; // Reserved positions written as zero
      wr_mode(v);
    end
    // Upper byte lane left alone when its strobe is low
    wr_mode(16'h0000);
    apb(1'b1, 8'h04, 32'h0000_ff7c, 4'h1);
    apb(1'b0, 8'h04, 32'h0, 4'h0);
    chk("lane_mask", rd, 32'h0000_007c);
    // Unmapped address refused and mode kept
    apb(1'b1, 8'h0c, 32'h0000_ffff, 4'hf);
    chk("bad_wr_err", err, 1'b1);
    apb(1'b0, 8'h0c, 32'h0, 4'h0);
    chk("bad_rd_err", err, 1'b1);
    chk("bad_rd_data", rd, 32'h0);
    apb(1'b0, 8'h04, 32'h0, 4'h0);
    chk("mode_kept", rd, 32'h0000_007c);
    give_verdict();
  end

endmodule
